// ---- core/wwd_top.sv ----
/*
  Window watchdog: 7-bit down counter, prescaler, window check,
  early-warning flag and interrupt, system reset request pulse.
  Assumes a single-cycle plain register port; debug_freeze_i and
  core_halted_i come from pins and are synchronised here.
*/
// Implementation choice: the strobed register port.
// How it works
// R1 - while running, the fall of the count from 0x40 to 0x3f asks reset.
// R2 - while running, a count write with count above window asks reset.
// R3 - the run bit at control bit 7 is set by software, only reset clears.
// R4 - after reset the watchdog is stopped and asks no reset.
// R5 - while running the count falls every 4096 times 1, 2, 4 or 8 clocks.
// R6 - the warning flag sets at count 0x40 or on an early refresh.
// R7 - writing zero to status bit 0 clears the flag, one leaves it.
// R8 - with config bit 9 and mask bit 0 set, the warning conditions raise the interrupt.
// R9 - config bit 9 is set by software, cleared by reset or wd soft reset.
// R10 - a 7-bit window in config bits 6:0 is checked on each count write.
// R11 - control bits 6:0 read the live count and load a refresh value.
// R12 - software loads above 0x3f and refreshes only inside the window.
// R13 - with freeze input high and core halted, counting stops.
// R14 - count and config reset to 0x7f.
// R15 - the reset request is a registered one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
module wwd_top
  import wwd_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic debug_freeze_i,
  input wire logic core_halted_i,
  input wire logic wd_soft_rst_i,
  output logic sys_reset_req_o,
  output logic early_warn_interrupt_o
);
  logic [6:0] count_value_reg;
  logic watchdog_run_bit_reg;
  logic [6:0] window_value_reg;
  logic [1:0] prescale_select_reg;
  logic early_warn_irq_en_reg;
  logic early_warn_flag_reg;
  logic mask_reg;
  logic [14:0] base_cnt_reg;
  logic [2:0] psc_cnt_reg;
  logic freeze_lvl;
  logic halt_lvl;
  logic [15:0] gap_reg;

  wwd_sync u_sync_frz (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .async_i(debug_freeze_i),
    .level_o(freeze_lvl)
  );
  wwd_sync u_sync_halt (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .async_i(core_halted_i),
    .level_o(halt_lvl)
  );

  // address decode
  wire sel_ctrl = (addr_i == WWD_OFS_CTRL);
  wire sel_cfg = (addr_i == WWD_OFS_CFG);
  wire sel_stat = (addr_i == WWD_OFS_STAT);
  wire sel_mask = (addr_i == WWD_OFS_MASK);
  wire wr_ctrl = wr_i && sel_ctrl;
  wire wr_cfg = wr_i && sel_cfg;
  wire wr_stat = wr_i && sel_stat;
  wire wr_mask = wr_i && sel_mask;

  // counting only while running and not frozen by debug
  wire frozen = freeze_lvl && halt_lvl; // see R13
  wire running = watchdog_run_bit_reg && !frozen; // see R4
  wire base_wrap = (base_cnt_reg == WWD_BASE_LAST); // see R5
  wire [2:0] psc_last = 3'((4'h1 << prescale_select_reg) - 4'h1); // see R5
  wire tick = running && base_wrap && (psc_cnt_reg == psc_last);

  // refresh write: the run bit may be set in the same write
  wire run_after = watchdog_run_bit_reg || (wr_ctrl && wdata_i[WWD_RUN_BIT]);
  wire refresh = wr_ctrl;
  // low seven data bits carry both the count and the window
  wire [6:0] wdata_low7 = wdata_i[6:0];
  // early refresh is judged against the live count, not the new one
  wire early = refresh && (count_value_reg > window_value_reg); // see R10
  wire fall_3f = tick && !refresh
    && (count_value_reg == WWD_CNT_WARN); // see R1
  wire reach_40 = tick && !refresh
    && (count_value_reg == WWD_CNT_WARN + 7'h01); // see R6
  wire warn_evt = reach_40 || (early && watchdog_run_bit_reg); // see R6
  wire rst_evt = watchdog_run_bit_reg && (fall_3f || early); // see R1 R2
  wire flag_clr = wr_stat && !wdata_i[WWD_FLAG_BIT]; // see R7

  // read mux, unmapped reads as zero
  wire [31:0] rd_mux =
    sel_ctrl ? {24'h000000, watchdog_run_bit_reg, count_value_reg} :
    sel_cfg ? {22'h000000, early_warn_irq_en_reg, prescale_select_reg,
               window_value_reg} :
    sel_stat ? {31'h00000000, early_warn_flag_reg} :
    sel_mask ? {31'h00000000, mask_reg} : WWD_DATA_ZERO;

  // prescaler: 4096 stage then power-of-two stage
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !running) begin
      base_cnt_reg <= 15'h0000;
    end else begin
      base_cnt_reg <= base_wrap ? 15'h0000 : base_cnt_reg + 15'h0001;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !watchdog_run_bit_reg) begin
      psc_cnt_reg <= 3'h0;
    end else if (running && base_wrap) begin
      psc_cnt_reg <= (psc_cnt_reg == psc_last) ? 3'h0 : psc_cnt_reg + 3'h1;
    end
  end

  // control: count and sticky run bit
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      count_value_reg <= WWD_CNT_RST; // see R14
      watchdog_run_bit_reg <= 1'b0; // see R4
    end else begin
      if (wr_ctrl && wdata_i[WWD_RUN_BIT]) begin
        watchdog_run_bit_reg <= 1'b1; // see R3
      end
      if (refresh) begin
        count_value_reg <= wdata_i[6:0]; // see R11
      end else if (tick) begin
        count_value_reg <= count_value_reg - 7'h01;
      end
    end
  end

  // config: irq enable set-only, cleared by the watchdog soft reset
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      window_value_reg <= WWD_WIN_RST; // see R14
      prescale_select_reg <= 2'h0;
      early_warn_irq_en_reg <= 1'b0;
    end else begin
      if (wr_cfg) begin
        window_value_reg <= wdata_i[6:0];
        prescale_select_reg <= wdata_i[WWD_PSC_LO +: 2];
      end
      if (wd_soft_rst_i) begin
        early_warn_irq_en_reg <= 1'b0; // see R9
      end else if (wr_cfg && wdata_i[WWD_IRQEN_BIT]) begin
        early_warn_irq_en_reg <= 1'b1; // see R9
      end
    end
  end

  // status flag: a new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      early_warn_flag_reg <= 1'b0;
      mask_reg <= 1'b1;
    end else begin
      if (warn_evt) begin
        early_warn_flag_reg <= 1'b1; // see R6
      end else if (flag_clr) begin
        early_warn_flag_reg <= 1'b0; // see R7
      end
      if (wr_mask) begin
        mask_reg <= wdata_i[0];
      end
    end
  end

  // outputs straight from flops
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      rdata_o <= WWD_DATA_ZERO;
      sys_reset_req_o <= 1'b0;
      early_warn_interrupt_o <= 1'b0;
    end else begin
      rdata_o <= rd_i ? rd_mux : WWD_DATA_ZERO;
      sys_reset_req_o <= rst_evt; // see R15
      early_warn_interrupt_o <= early_warn_flag_reg
        && early_warn_irq_en_reg && mask_reg; // see R8
    end
  end

  // helper: cycles since the last tick or since counting resumed
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || !running || tick) begin
      gap_reg <= 16'h0000;
    end else if (gap_reg != 16'hffff) begin
      gap_reg <= gap_reg + 16'h0001;
    end
  end

  // checks
  property p_fall_reset; // see R1
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      fall_3f && watchdog_run_bit_reg |=> sys_reset_req_o
        && count_value_reg == 7'h3f;
  endproperty
  a_fall_reset: assert property (p_fall_reset) // see R1
    else $error("no reset on fall to 3f");

  property p_early_reset; // see R2
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      wr_ctrl && watchdog_run_bit_reg
        && count_value_reg > window_value_reg |=> sys_reset_req_o;
  endproperty
  a_early_reset: assert property (p_early_reset) // see R2
    else $error("no reset on early refresh");

  property p_run_sticky; // see R3
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      watchdog_run_bit_reg |=> watchdog_run_bit_reg;
  endproperty
  a_run_sticky: assert property (p_run_sticky) // see R3
    else $error("run bit cleared");

  property p_idle_quiet; // see R4
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      !watchdog_run_bit_reg && !wr_ctrl |=> !sys_reset_req_o
        && $stable(count_value_reg);
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) // see R4
    else $error("activity while stopped");

  property p_tick_rate; // see R5
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      tick |=> !tick [*8];
  endproperty
  a_tick_rate: assert property (p_tick_rate) // see R5
    else $error("ticks too close");

  property p_flag_set; // see R6
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      reach_40 |=> early_warn_flag_reg && count_value_reg == 7'h40;
  endproperty
  a_flag_set: assert property (p_flag_set) // see R6
    else $error("flag not set at 40");

  property p_flag_clr; // see R7
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      flag_clr && !warn_evt |=> !early_warn_flag_reg;
  endproperty
  a_flag_clr: assert property (p_flag_clr) // see R7
    else $error("flag not cleared");

  property p_irq; // see R8
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      early_warn_interrupt_o |-> $past(early_warn_flag_reg)
        && $past(early_warn_irq_en_reg);
  endproperty
  a_irq: assert property (p_irq) // see R8
    else $error("irq without cause");

  property p_freeze; // see R13
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      frozen && !wr_ctrl |=> $stable(count_value_reg);
  endproperty
  a_freeze: assert property (p_freeze) // see R13
    else $error("count moved while frozen");

  property p_pulse; // see R15
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      $rose(sys_reset_req_o) |-> $past(rst_evt);
  endproperty
  a_pulse: assert property (p_pulse) // see R15
    else $error("reset pulse without cause");

  property p_early_flag;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      early && watchdog_run_bit_reg |=> early_warn_flag_reg;
  endproperty
  a_early_flag: assert property (p_early_flag) // see R6
    else $error("flag not set on early refresh");

  property p_irq_raise;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      early_warn_flag_reg && early_warn_irq_en_reg && mask_reg
        |=> early_warn_interrupt_o;
  endproperty
  a_irq_raise: assert property (p_irq_raise) // see R8
    else $error("irq not raised");

  property p_irqen_sticky;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      early_warn_irq_en_reg && !wd_soft_rst_i |=> early_warn_irq_en_reg;
  endproperty
  a_irqen_sticky: assert property (p_irqen_sticky) // see R9
    else $error("irq enable cleared by a write");

  property p_soft_clr;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      wd_soft_rst_i |=> !early_warn_irq_en_reg;
  endproperty
  a_soft_clr: assert property (p_soft_clr) // see R9
    else $error("soft reset kept irq enable");

  property p_win_load;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      wr_cfg |=> window_value_reg == $past(wdata_low7);
  endproperty
  a_win_load: assert property (p_win_load) // see R10
    else $error("window not loaded");

  property p_refresh_load;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      refresh |=> count_value_reg == $past(wdata_low7);
  endproperty
  a_refresh_load: assert property (p_refresh_load) // see R11
    else $error("refresh value not loaded");

  // a tick needs at least one full pass of the 4096 stage
  property p_tick_gap;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      tick |-> gap_reg >= {1'b0, WWD_BASE_LAST};
  endproperty
  a_tick_gap: assert property (p_tick_gap) // see R5
    else $error("tick before the base period");

  property p_pulse_one;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      sys_reset_req_o && !rst_evt |=> !sys_reset_req_o;
  endproperty
  a_pulse_one: assert property (p_pulse_one) // see R15
    else $error("reset pulse held without cause");

  // read data stand only in the cycle after a read strobe
  property p_rdata_idle;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
      !rd_i |=> rdata_o == WWD_DATA_ZERO;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) // see R11
    else $error("read data without a read");

  c_fall: cover property (@(posedge clk_sys_i) fall_3f);
  c_early: cover property (@(posedge clk_sys_i) early && run_after);
  c_irq: cover property (@(posedge clk_sys_i) $rose(early_warn_interrupt_o));
  c_freeze: cover property (@(posedge clk_sys_i) frozen && running == 1'b0);
endmodule : wwd_top
`default_nettype wire

// ---- inc/wwd_pkg.sv ----
/*
  Package for the window watchdog: register offsets, field positions,
  reset values and the fixed prescaler count.
  Assumes a 32-bit plain register port with word offsets.
*/
package wwd_pkg;
  localparam logic [7:0] WWD_OFS_CTRL = 8'h00;
  localparam logic [7:0] WWD_OFS_CFG = 8'h04;
  localparam logic [7:0] WWD_OFS_STAT = 8'h08;
  localparam logic [7:0] WWD_OFS_MASK = 8'h0c;
  localparam int WWD_RUN_BIT = 7;
  localparam int WWD_PSC_LO = 7;
  localparam int WWD_IRQEN_BIT = 9;
  localparam int WWD_FLAG_BIT = 0;
  localparam logic [6:0] WWD_CNT_RST = 7'h7f;
  localparam logic [6:0] WWD_WIN_RST = 7'h7f;
  localparam logic [6:0] WWD_CNT_WARN = 7'h40;
  localparam int WWD_BASE_DIV = 4096;
  localparam logic [14:0] WWD_BASE_LAST = 15'(WWD_BASE_DIV - 1);
  localparam logic [31:0] WWD_DATA_ZERO = 32'h0000_0000;
endpackage : wwd_pkg

// ---- core/wwd_sync.sv ----
/*
  Three-stage input synchroniser for pin-level signals.
  Assumes the input is asynchronous to clk_sys_i.
*/
`timescale 1ns/1ps
`default_nettype none
module wwd_sync (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic async_i,
  output logic level_o
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // level changes only once the last two stages agree
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1_reg <= async_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_o <= s3_reg;
      end
    end
  end
endmodule : wwd_sync
`default_nettype wire

// ---- tb/wwd_tb.sv ----
/*
  Self-checking bench for wwd_top: reset values, sticky bits, prescale
  codes, debug freeze, window refresh, warning flag and run-out reset.
  Assumes the plain register port with read data one cycle after rd_i.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin \
  n_errors++; $display("MISMATCH %s exp %h got %h", n, e, s); end end
module tb;
  import wwd_pkg::*;
  logic clk_sys_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic frz = 1'b0, hlt = 1'b0, srst = 1'b0, rst_o, irq_o, ir;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, rdata_o, rv, seed = 32'hcc41;
  int n_errors = 0, num_checks = 0, n_rst = 0, cyc = 0, t0 = 0, d, c0;
  // register model: set-only bits and plain fields, no timing
  logic m_run = 1'b0, m_mask = 1'b1;
  logic [31:0] m_cfg = 32'h0000_007f;
  logic [31:0] exp_q[$];
  wwd_top DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .debug_freeze_i(frz), .core_halted_i(hlt), .wd_soft_rst_i(srst),
    .sys_reset_req_o(rst_o), .early_warn_interrupt_o(irq_o));
  // 10 MHz system clock
  initial begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  // cycle count and reset pulses seen, for the model
  always @(posedge clk_sys_i) begin
    cyc++;
    if (rst_o === 1'b1) n_rst++;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // idle edge after each write keeps strobes from being driven twice
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    // model: run bit and irq enable only ever set by a write
    if (a == WWD_OFS_CTRL) m_run = m_run | v[WWD_RUN_BIT];
    if (a == WWD_OFS_MASK) m_mask = v[0];
    if (a == WWD_OFS_CFG) begin
      m_cfg[8:0] = v[8:0];
      m_cfg[WWD_IRQEN_BIT] = m_cfg[WWD_IRQEN_BIT] | v[WWD_IRQEN_BIT];
    end
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask : wr
  // samples read data and interrupt once the edge has settled
  task automatic rd(input logic [7:0] a);
    logic [31:0] ex;
    addr_i <= a;
    rd_i <= 1'b1;
    // expected value queued at the request, taken with the data
    if (a == WWD_OFS_CFG) exp_q.push_back(m_cfg);
    else if (a == WWD_OFS_MASK) exp_q.push_back({31'h0, m_mask});
    else if (a > WWD_OFS_MASK) exp_q.push_back(32'h0);
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 rv = rdata_o;
    ir = irq_o;
    if (exp_q.size() > 0) begin
      ex = exp_q.pop_front();
      `CHK("model reg", ex, rv)
    end
    if (a == WWD_OFS_CTRL) `CHK("model run", m_run, rv[WWD_RUN_BIT])
    @(posedge clk_sys_i);
  endtask : rd
  // polls the count until it moves; polling step is even, so the
  // detection lag cancels out of the measured period
  task automatic tick();
    int k;
    rd(WWD_OFS_CTRL);
    c0 = rv[6:0];
    for (k = 0; k < 20000 && rv[6:0] === c0[6:0]; k++) rd(WWD_OFS_CTRL);
    d = cyc - t0;
    t0 = cyc;
    `CHK("count step", 7'(c0 - 1), rv[6:0])
  endtask : tick
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run
  // hang guard, well past the planned run of about 90k cycles
  initial begin
    repeat (150000) @(posedge clk_sys_i);
    n_errors++;
    complete_run();
  end
  initial begin
    repeat (8) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    // reset values, then a random unmapped place
    rd(WWD_OFS_CTRL);
    `CHK("ctrl rst", 32'h0000_007f, rv)
    rd(WWD_OFS_CFG);
    `CHK("cfg rst", 32'h0000_007f, rv)
    rd(WWD_OFS_STAT);
    `CHK("stat rst", 32'h0, rv)
    rd(WWD_OFS_MASK);
    `CHK("mask rst", 32'h1, rv)
    seed = xs(seed);
    wr({2'b01, seed[3:0], 2'b00}, seed);
    rd({2'b01, seed[3:0], 2'b00});
    `CHK("unmapped", 32'h0, rv)
    repeat (5000) @(posedge clk_sys_i);
    rd(WWD_OFS_CTRL);
    `CHK("idle count", 32'h0000_007f, rv)
    `CHK("idle reset", 0, n_rst)
    // enable; zero writes must not clear the sticky bits
    wr(WWD_OFS_CFG, 32'h0000_027f);
    wr(WWD_OFS_CTRL, 32'h0000_00ff);
    wr(WWD_OFS_CTRL, 32'h0000_007f);
    wr(WWD_OFS_CFG, 32'h0000_007f);
    rd(WWD_OFS_CTRL);
    `CHK("run bit", 1'b1, rv[7])
    rd(WWD_OFS_CFG);
    `CHK("irq en kept", 32'h0000_027f, rv)
    srst <= 1'b1;
    @(posedge clk_sys_i);
    srst <= 1'b0;
    m_cfg[WWD_IRQEN_BIT] = 1'b0;
    rd(WWD_OFS_CFG);
    `CHK("soft reset", 32'h0000_007f, rv)
    // each prescale code, measured from one count step to the next
    tick();
    for (int p = 0; p < 4; p++) begin
      wr(WWD_OFS_CFG, {23'h0, p[1:0], 7'h7f});
      tick();
      `CHK("period", WWD_BASE_DIV << p, d)
    end
    // freeze holds only while both inputs are high
    wr(WWD_OFS_CFG, 32'h0000_007f);
    frz <= 1'b1;
    hlt <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    rd(WWD_OFS_CTRL);
    c0 = rv[6:0];
    repeat (5000) @(posedge clk_sys_i);
    rd(WWD_OFS_CTRL);
    `CHK("frozen", c0[6:0], rv[6:0])
    hlt <= 1'b0;
    repeat (5000) @(posedge clk_sys_i);
    rd(WWD_OFS_CTRL);
    `CHK("not frozen", 7'(c0 - 1), rv[6:0])
    frz <= 1'b0;
    // refresh above a random window: reset, flag and interrupt
    seed = xs(seed);
    wr(WWD_OFS_CFG, {22'h0, 1'b1, 2'b00, 2'b10, seed[4:0]});
    wr(WWD_OFS_CTRL, 32'h0000_007f);
    rd(WWD_OFS_STAT);
    `CHK("early reset", 1, n_rst)
    `CHK("early flag", 32'h1, rv)
    `CHK("early irq", 1'b1, ir)
    wr(WWD_OFS_MASK, 32'h0);
    rd(WWD_OFS_STAT);
    `CHK("masked irq", 1'b0, ir)
    wr(WWD_OFS_MASK, 32'h1);
    wr(WWD_OFS_STAT, 32'h1);
    rd(WWD_OFS_STAT);
    `CHK("write one", 32'h1, rv)
    `CHK("irq back", 1'b1, ir)
    wr(WWD_OFS_STAT, 32'h0);
    rd(WWD_OFS_STAT);
    `CHK("cleared", 32'h0, rv)
    `CHK("irq off", 1'b0, ir)
    // run-out: warning at 0x40, then reset on the step to 0x3f
    wr(WWD_OFS_CFG, 32'h0000_027f);
    // refreshes inside the window keep the run quiet
    seed = xs(seed);
    wr(WWD_OFS_CTRL, {24'h0, 3'b111, seed[4:0]});
    wr(WWD_OFS_CTRL, 32'h0000_0041);
    rd(WWD_OFS_STAT);
    `CHK("in-window flag", 32'h0, rv)
    `CHK("in-window reset", 1, n_rst)
    for (int k = 0; k < 3000 && rv[0] !== 1'b1; k++) rd(WWD_OFS_STAT);
    rd(WWD_OFS_CTRL);
    `CHK("warn count", WWD_CNT_WARN, rv[6:0])
    `CHK("warn irq", 1'b1, ir)
    `CHK("no reset yet", 1, n_rst)
    for (int k = 0; k < 5000 && n_rst < 2; k++) @(posedge clk_sys_i);
    rd(WWD_OFS_CTRL);
    `CHK("run-out reset", 2, n_rst)
    `CHK("end count", 7'h3f, rv[6:0])
    // reset in mid-run: only this clears the run bit; it also clears irq enable
    rst_n_i <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    m_run = 1'b0;
    m_mask = 1'b1;
    m_cfg = 32'h0000_007f;
    @(posedge clk_sys_i);
    rd(WWD_OFS_CTRL);
    `CHK("rerun ctrl", 32'h0000_007f, rv)
    rd(WWD_OFS_CFG);
    `CHK("rerun cfg", 32'h0000_007f, rv)
    rd(WWD_OFS_STAT);
    `CHK("rerun flag", 32'h0, rv)
    repeat (300) @(posedge clk_sys_i);
    `CHK("rerun quiet", 2, n_rst)
    complete_run();
  end
endmodule : tb
`undef CHK
`default_nettype wire
